// [src/rwp_consts.vh]
// constants for the register write-protection bank
`ifndef RWP_CONSTS_VH
`define RWP_CONSTS_VH
// register indices; byte address is four times the index
`define RWP_IDX_MAIN_PROT 10'h010
`define RWP_IDX_SECOND_PROT 10'h011
`define RWP_IDX_THIRD_PROT 10'h012
`define RWP_IDX_FOURTH_PROT 10'h013
`define RWP_IDX_KEY_RELEASE 10'h014
`define RWP_IDX_BUS_TIMING 10'h01E
`define RWP_IDX_SLOT_BASE 10'h040
`define RWP_SLOT_COUNT 53
// unlock bit positions
`define RWP_BIT_CLOCK 0
`define RWP_BIT_MODE 1
`define RWP_BIT_PORT9 2
`define RWP_BIT_CM3 0
`define RWP_BIT_PORT378 0
`define RWP_BIT_VOLTAGE 1
`define RWP_BIT_WDT 0
`define RWP_BIT_DFLASH 1
// key value that opens the key-guarded registers
`define RWP_KEY_OPEN 8'hAA
// bus timing register
`define RWP_BUS_TIMING_RST 16'h0504
`define RWP_RD_WAIT_LSB 0
`define RWP_WR_WAIT_LSB 8
`define RWP_WAIT_W 5
`define RWP_SLOT_RST 8'h00
// protection groups of the slot area
`define RWP_GRP_CLOCK 4'h0
`define RWP_GRP_MODE 4'h1
`define RWP_GRP_PORT9 4'h2
`define RWP_GRP_CM3 4'h3
`define RWP_GRP_PORT378 4'h4
`define RWP_GRP_VOLTAGE 4'h5
`define RWP_GRP_WDT 4'h6
`define RWP_GRP_DFLASH 4'h7
`define RWP_GRP_KEY 4'h8
// first slot of each group, ranges are contiguous
`define RWP_SLOT_MODE 6'h04
`define RWP_SLOT_PORT9 6'h09
`define RWP_SLOT_CM3 6'h11
`define RWP_SLOT_PORT378 6'h12
`define RWP_SLOT_VOLTAGE 6'h2D
`define RWP_SLOT_WDT 6'h30
`define RWP_SLOT_DFLASH 6'h31
`define RWP_SLOT_KEY 6'h32
// axi responses
`define RWP_RESP_OKAY 2'b00
`define RWP_RESP_SLVERR 2'b10
`endif

// [src/rwp_protect_bank.v]
// register write-protection bank with AXI4-Lite slave
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// Notes on behaviour
// - clock mode a/b/c and processor mode d writable only while clock_reg_unlock is 1.
// - processor mode a/c, inverter ctrl a/b, io buffer ctrl gated by mode_reg_unlock.
// - pin level ctrl a/b, port nine direction and selects 3..7 gated by port9_unlock.
// - port9_unlock clears itself on the next write to any address but the main protect register, which loads it from the data.
// - clock and mode unlock bits hold until software writes them 0.
// - second protect register guards only clock mode d.
// - port378_unlock gates direction and selects of ports 3, 7, 8 bits 0..7.
// - voltage_reg_unlock gates regulator, low voltage detect and voltage detect ctrl.
// - fourth protect register bits gate watchdog start and data flash mode.
// - clock ctrl, flash mode ctrl, bus timing, ext bus ctrl need key value AAh.
// - bus interface unit takes read and write wait states from bus timing fields.
`include "rwp_consts.vh"

module rwp_protect_bank #(
  parameter ADDR_W = 12,
  parameter SLOTS = `RWP_SLOT_COUNT
) (
  input wire clk,
  input wire rst,
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  output wire [`RWP_WAIT_W-1:0] read_wait_field,
  output wire [`RWP_WAIT_W-1:0] write_wait_field,
  output wire write_blocked
);

  reg aw_held_ff;
  reg [ADDR_W-1:0] aw_addr_ff;
  reg w_held_ff;
  reg [31:0] w_data_ff;
  reg [3:0] w_strb_ff;
  reg bvalid_ff;
  reg [1:0] bresp_ff;
  reg rvalid_ff;
  reg [1:0] rresp_ff;
  reg [31:0] rdata_ff;
  reg blocked_ff;

  reg [2:0] main_protect_reg_ff;
  reg second_protect_reg_ff;
  reg [1:0] third_protect_reg_ff;
  reg [1:0] fourth_protect_reg_ff;
  reg [7:0] key_release_reg_ff;
  reg [15:0] bus_timing_reg_ff;
  reg [7:0] slot_ff [0:SLOTS-1];

  wire do_wr;
  wire [9:0] wr_idx;
  wire [9:0] wr_slot_off;
  wire [5:0] wr_slot;
  wire wr_in_slots;
  wire [9:0] rd_idx;
  wire [9:0] rd_slot_off;
  wire [5:0] rd_slot;
  wire rd_in_slots;
  wire key_open;
  reg wr_allow;
  reg wr_mapped;
  reg rd_mapped;
  reg [31:0] rd_value;
  wire slot_wr_en;
  wire timing_wr_en;

  // map a slot to its protection group
  // groups occupy ordered ranges, so a chain of compares is enough
  function [3:0] grp_of;
    input [5:0] slot;
    begin
      if (slot < `RWP_SLOT_MODE) begin
        grp_of = `RWP_GRP_CLOCK;
      end else if (slot < `RWP_SLOT_PORT9) begin
        grp_of = `RWP_GRP_MODE;
      end else if (slot < `RWP_SLOT_CM3) begin
        grp_of = `RWP_GRP_PORT9;
      end else if (slot < `RWP_SLOT_PORT378) begin
        grp_of = `RWP_GRP_CM3;
      end else if (slot < `RWP_SLOT_VOLTAGE) begin
        grp_of = `RWP_GRP_PORT378;
      end else if (slot < `RWP_SLOT_WDT) begin
        grp_of = `RWP_GRP_VOLTAGE;
      end else if (slot < `RWP_SLOT_DFLASH) begin
        grp_of = `RWP_GRP_WDT;
      end else if (slot < `RWP_SLOT_KEY) begin
        grp_of = `RWP_GRP_DFLASH;
      end else begin
        grp_of = `RWP_GRP_KEY;
      end
    end
  endfunction

  // write channels are taken independently, then applied together
  // readies stay low while a response waits, so one write at most is in flight
  assign s_axi_awready = !aw_held_ff && !bvalid_ff;
  assign s_axi_wready = !w_held_ff && !bvalid_ff;
  assign do_wr = aw_held_ff && w_held_ff && !bvalid_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rresp = rresp_ff;
  assign s_axi_rdata = rdata_ff;
  assign write_blocked = blocked_ff;

  assign wr_idx = aw_addr_ff[11:2];
  assign wr_slot_off = wr_idx - `RWP_IDX_SLOT_BASE;
  assign wr_slot = wr_slot_off[5:0];
  assign wr_in_slots = (wr_idx >= `RWP_IDX_SLOT_BASE) && (wr_slot_off < SLOTS);
  assign rd_idx = s_axi_araddr[11:2];
  assign rd_slot_off = rd_idx - `RWP_IDX_SLOT_BASE;
  assign rd_slot = rd_slot_off[5:0];
  assign rd_in_slots = (rd_idx >= `RWP_IDX_SLOT_BASE) && (rd_slot_off < SLOTS);
  // any key but the open value locks, so one stray byte rarely unlocks the group
  assign key_open = (key_release_reg_ff == `RWP_KEY_OPEN);

  // shared enables keep the per-slot logic to a single index compare
  assign slot_wr_en = do_wr && wr_in_slots && wr_allow && w_strb_ff[0];
  // the bus timing register sits outside the slot area but shares the key
  assign timing_wr_en = do_wr && (wr_idx == `RWP_IDX_BUS_TIMING) && key_open;

  // the timing fields steer the peripheral bus adapter directly
  assign read_wait_field = bus_timing_reg_ff[`RWP_RD_WAIT_LSB +: `RWP_WAIT_W];
  assign write_wait_field = bus_timing_reg_ff[`RWP_WR_WAIT_LSB +: `RWP_WAIT_W];

  // decide whether the pending write lands
  // unmapped addresses answer slverr and store nothing, but still count as a write
  always @* begin
    wr_mapped = 1'b1;
    wr_allow = 1'b1;
    if (wr_in_slots) begin
      case (grp_of(wr_slot))
        `RWP_GRP_CLOCK: wr_allow = main_protect_reg_ff[`RWP_BIT_CLOCK];
        `RWP_GRP_MODE: wr_allow = main_protect_reg_ff[`RWP_BIT_MODE];
        `RWP_GRP_PORT9: wr_allow = main_protect_reg_ff[`RWP_BIT_PORT9];
        `RWP_GRP_CM3: wr_allow = second_protect_reg_ff;
        `RWP_GRP_PORT378: wr_allow = third_protect_reg_ff[`RWP_BIT_PORT378];
        `RWP_GRP_VOLTAGE: wr_allow = third_protect_reg_ff[`RWP_BIT_VOLTAGE];
        `RWP_GRP_WDT: wr_allow = fourth_protect_reg_ff[`RWP_BIT_WDT];
        `RWP_GRP_DFLASH: wr_allow = fourth_protect_reg_ff[`RWP_BIT_DFLASH];
        default: wr_allow = key_open;
      endcase
    end else begin
      case (wr_idx)
        `RWP_IDX_MAIN_PROT: wr_allow = 1'b1;
        `RWP_IDX_SECOND_PROT: wr_allow = 1'b1;
        `RWP_IDX_THIRD_PROT: wr_allow = 1'b1;
        `RWP_IDX_FOURTH_PROT: wr_allow = 1'b1;
        `RWP_IDX_KEY_RELEASE: wr_allow = 1'b1;
        `RWP_IDX_BUS_TIMING: wr_allow = key_open;
        default: begin
          wr_mapped = 1'b0;
          wr_allow = 1'b0;
        end
      endcase
    end
  end

  // write address and data holding, response
  always @(posedge clk) begin
    if (rst) begin
      aw_held_ff <= 1'b0;
      aw_addr_ff <= {ADDR_W{1'b0}};
      w_held_ff <= 1'b0;
      w_data_ff <= 32'h00000000;
      w_strb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= `RWP_RESP_OKAY;
      blocked_ff <= 1'b0;
    end else begin
      blocked_ff <= 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_ff <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_held_ff <= 1'b0;
        w_held_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_mapped ? `RWP_RESP_OKAY : `RWP_RESP_SLVERR;
        // locked writes answer okay but are dropped
        blocked_ff <= wr_mapped && !wr_allow;
      end else if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // protect, key and bus timing registers
  always @(posedge clk) begin
    if (rst) begin
      main_protect_reg_ff <= 3'b000;
      second_protect_reg_ff <= 1'b0;
      third_protect_reg_ff <= 2'b00;
      fourth_protect_reg_ff <= 2'b00;
      key_release_reg_ff <= 8'h00;
      bus_timing_reg_ff <= `RWP_BUS_TIMING_RST;
    end else if (do_wr) begin
      // any other write, even unmapped or blocked, drops the one-shot unlock
      main_protect_reg_ff[`RWP_BIT_PORT9] <= 1'b0;
      if (w_strb_ff[0]) begin
        case (wr_idx)
          `RWP_IDX_MAIN_PROT: main_protect_reg_ff <= w_data_ff[2:0];
          `RWP_IDX_SECOND_PROT: second_protect_reg_ff <= w_data_ff[`RWP_BIT_CM3];
          `RWP_IDX_THIRD_PROT: third_protect_reg_ff <= w_data_ff[1:0];
          `RWP_IDX_FOURTH_PROT: fourth_protect_reg_ff <= w_data_ff[1:0];
          `RWP_IDX_KEY_RELEASE: key_release_reg_ff <= w_data_ff[7:0];
          default: begin
          end
        endcase
      end
      // reserved bits are stored as written; keeping them zero is left to software
      if (timing_wr_en) begin
        if (w_strb_ff[0]) begin
          bus_timing_reg_ff[7:0] <= w_data_ff[7:0];
        end
        if (w_strb_ff[1]) begin
          bus_timing_reg_ff[15:8] <= w_data_ff[15:8];
        end
      end
    end
  end

  // guarded register storage, one entry per protected register
  // copies start at zero, matching the locked state after reset
  genvar g;
  generate
    for (g = 0; g < SLOTS; g = g + 1) begin : g_slot
      always @(posedge clk) begin
        if (rst) begin
          slot_ff[g] <= `RWP_SLOT_RST;
        end else if (slot_wr_en && wr_slot == g) begin
          slot_ff[g] <= w_data_ff[7:0];
        end
      end
    end
  endgenerate

  // read decode
  always @* begin
    rd_mapped = 1'b1;
    rd_value = 32'h00000000;
    if (rd_in_slots) begin
      rd_value = {24'h000000, slot_ff[rd_slot]};
    end else begin
      case (rd_idx)
        `RWP_IDX_MAIN_PROT: rd_value = {29'h00000000, main_protect_reg_ff};
        `RWP_IDX_SECOND_PROT: rd_value = {31'h00000000, second_protect_reg_ff};
        `RWP_IDX_THIRD_PROT: rd_value = {30'h00000000, third_protect_reg_ff};
        `RWP_IDX_FOURTH_PROT: rd_value = {30'h00000000, fourth_protect_reg_ff};
        `RWP_IDX_KEY_RELEASE: rd_value = {24'h000000, key_release_reg_ff};
        `RWP_IDX_BUS_TIMING: rd_value = {16'h0000, bus_timing_reg_ff};
        default: rd_mapped = 1'b0;
      endcase
    end
  end

  // read channel, data captured when the address is taken
  // a write landing while rvalid waits shows only on the next read
  always @(posedge clk) begin
    if (rst) begin
      rvalid_ff <= 1'b0;
      rresp_ff <= `RWP_RESP_OKAY;
      rdata_ff <= 32'h00000000;
    end else if (s_axi_arvalid && !rvalid_ff) begin
      rvalid_ff <= 1'b1;
      rresp_ff <= rd_mapped ? `RWP_RESP_OKAY : `RWP_RESP_SLVERR;
      rdata_ff <= rd_value;
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

endmodule // rwp_protect_bank

// [sim/rwp_bank_assertions.sv]
// concurrent checks on the write-protection bank ports
`timescale 1ns/1ps
`include "rwp_consts.vh"
module rwp_bank_checker (
  input wire clk,
  input wire rst,
  input wire s_axi_awready,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [`RWP_WAIT_W-1:0] read_wait_field,
  input wire [`RWP_WAIT_W-1:0] write_wait_field,
  input wire write_blocked
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  AST_BLK_ON_RISE: assert property (
    write_blocked |-> $rose(s_axi_bvalid) && s_axi_bresp == `RWP_RESP_OKAY)
    else $error("blocked pulse not on an okay response");
  AST_BLK_ONE: assert property (write_blocked |=> !write_blocked)
    else $error("blocked pulse longer than one cycle");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  AST_R_ANS: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_NO_NEW_AW: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted with response pending");
  AST_RST_WAIT: assert property (
    $past(rst) |-> read_wait_field == 5'h04 && write_wait_field == 5'h05)
    else $error("wait fields not at reset value");
  // only a completed, unblocked write may move the wait fields; a reset edge is excused
  AST_WAIT_CAUSE: assert property (
    !$stable({read_wait_field, write_wait_field}) && !$past(rst)
      |-> $rose(s_axi_bvalid) && !write_blocked)
    else $error("wait fields changed without a write");
  cover property (write_blocked);
  cover property (s_axi_bvalid && !s_axi_bready);
  cover property ($rose(s_axi_bvalid) && s_axi_bresp == 2'b10);
  cover property (s_axi_rvalid && s_axi_rready);
endmodule // rwp_bank_checker
bind rwp_protect_bank rwp_bank_checker chk_u (.clk, .rst, .s_axi_awready, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .read_wait_field, .write_wait_field, .write_blocked);

// [sim/rwp_tb.sv]
// self-checking bench for the write-protection bank
`timescale 1ns/1ps
`include "rwp_consts.vh"
module tb;
  logic clk = 0, rst = 1;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0, pa, sa, kr, mp;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [31:0] s_axi_wdata = 0, got, ov;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, write_blocked;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [4:0] read_wait_field, write_wait_field;
  logic [1:0] rsp;
  logic wb;
  int n_mismatch = 0, n_checks = 0;
  int lo[9] = '{0, 4, 9, 17, 18, 45, 48, 49, 50};
  int hi[9] = '{3, 8, 16, 17, 44, 47, 48, 49, 52};
  int pr[9] = '{0, 0, 0, 1, 2, 2, 3, 3, 4};
  int bt[9] = '{0, 1, 2, 0, 0, 1, 0, 1, 0};
  initial forever #12.5 clk = ~clk;
  rwp_protect_bank dut_u (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .read_wait_field,
    .write_wait_field, .write_blocked);
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      n_mismatch++;
    end
  endtask
  // everything is judged on values sampled at the rising edge, answer taken at the handshake
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
    logic dn;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_arvalid <= !w;
    dn = 0;
    wb = 0;
    while (!dn) begin
      @(posedge clk);
      dn = w ? s_axi_bvalid && s_axi_bready : s_axi_rvalid && s_axi_rready;
      got = s_axi_rdata;
      rsp = w ? s_axi_bresp : s_axi_rresp;
      if (write_blocked) wb = 1;
      if (s_axi_awvalid && s_axi_awready || s_axi_arvalid && s_axi_arready) begin
        s_axi_awvalid <= 0;
        s_axi_arvalid <= 0;
      end
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
      // ready lags the answer by a cycle so a waiting response is seen held
      if (!dn && (s_axi_bvalid || s_axi_rvalid)) begin
        s_axi_bready <= w;
        s_axi_rready <= !w;
      end
    end
    s_axi_bready <= 0;
    s_axi_rready <= 0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    acc(0, a, 0);
    chk("rdata", e, got);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r,
                    input logic b);
    acc(1, a, d);
    chk("bresp", r, rsp);
    chk("write_blocked", b, wb);
  endtask
  task automatic stop_test;
    if (n_mismatch == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (10000) @(posedge clk);
    n_mismatch++;
    stop_test;
  end
  initial begin
    pa = {`RWP_IDX_BUS_TIMING, 2'b00};
    kr = {`RWP_IDX_KEY_RELEASE, 2'b00};
    mp = {`RWP_IDX_MAIN_PROT, 2'b00};
    repeat (4) @(posedge clk);
    rst <= 0;
    chk("read_wait", 5'h04, read_wait_field);
    chk("write_wait", 5'h05, write_wait_field);
    rd(pa, 32'h0504);
    wr(pa, 32'h0F0F, 2'b00, 1);
    rd(pa, 32'h0504);
    wr(kr, 32'hAA, 2'b00, 0);
    wr(pa, 32'h0F0F, 2'b00, 0);
    chk("read_wait", 5'h0F, read_wait_field);
    chk("write_wait", 5'h0F, write_wait_field);
    wr(kr, 32'h55, 2'b00, 0);
    wr(pa, 32'h0504, 2'b00, 1);
    rd(pa, 32'h0F0F);
    wr(mp, 32'h4, 2'b00, 0);
    wr(12'hFFC, 0, 2'b10, 0);
    rd(mp, 0);
    rd(12'hFFC, 0);
    chk("rresp", 2'b10, rsp);
    for (int g = 0; g < 9; g++) begin
      pa = mp + 12'(4 * pr[g]);
      ov = (g == 8) ? 32'hAA : 32'h1 << bt[g];
      for (int k = 0; k < 2; k++) begin
        sa = {`RWP_IDX_SLOT_BASE, 2'b00} + 12'(4 * (k ? hi[g] : lo[g]));
        wr(sa, 32'h5A, 2'b00, 1);
        rd(sa, (k && hi[g] == lo[g]) ? 32'hC3 : 0);
        wr(pa, ov, 2'b00, 0);
        wr(sa, 32'hC3, 2'b00, 0);
        rd(sa, 32'hC3);
        rd(pa, g == 2 ? 0 : ov);
        wr(pa, 0, 2'b00, 0);
      end
    end
    // a reset in mid-run must relock everything and restore the timing fields
    wr(mp, 32'h3, 2'b00, 0);
    @(posedge clk);
    rst <= 1;
    repeat (2) @(posedge clk);
    rst <= 0;
    rd(mp, 0);
    rd({`RWP_IDX_BUS_TIMING, 2'b00}, 32'h0504);
    chk("read_wait", 5'h04, read_wait_field);
    chk("write_wait", 5'h05, write_wait_field);
    wr({`RWP_IDX_SLOT_BASE, 2'b00}, 32'h5A, 2'b00, 1);
    rd({`RWP_IDX_SLOT_BASE, 2'b00}, 0);
    stop_test;
  end
endmodule // tb
